// File: rtl/cst_pkg.sv
// Constants shared by the cold-reset strap capture and debug trace block.
// Assumes one 25 MHz clock; all values here are fixed by the device pin-out.
package cst_pkg;

  // Clock and timing.
  localparam int CST_CLK_PERIOD_NS = 40;
  localparam int CST_SYNC_STAGES = 2;

  // Mode word layout latched at cold reset.
  localparam int CST_MODE_W = 10;
  localparam int CST_MB_MULT_LSB = 0;
  localparam int CST_MB_MULT_MSB = 2;
  localparam int CST_MB_BYTE_ORDER = 3;
  localparam int CST_MB_RSV4 = 4;
  localparam int CST_MB_RSV5 = 5;
  localparam int CST_MB_TIMER_DIS = 6;
  localparam int CST_MB_RSV7 = 7;
  localparam int CST_MB_WIDTH_LSB = 8;
  localparam int CST_MB_WIDTH_MSB = 9;

  // Address strap pins carrying mode and boot settings.
  localparam int CST_ADDR_LSB = 17;
  localparam int CST_ADDR_MSB = 22;
  localparam int CST_ADDR_RSV7 = 17;
  localparam int CST_ADDR_WIDTH_LSB = 18;
  localparam int CST_ADDR_WIDTH_MSB = 19;
  localparam int CST_ADDR_PCI_ROLE = 20;
  localparam int CST_ADDR_BOOT_LSB = 21;
  localparam int CST_ADDR_BOOT_MSB = 22;

  // Strapped levels that reserved mode bits must carry.
  localparam logic CST_RSV4_LEVEL = 1'h0;
  localparam logic CST_RSV5_LEVEL = 1'h0;
  localparam logic CST_RSV7_LEVEL = 1'h1;

  // Clock multiplier codes and resulting ratios.
  localparam logic [2:0] CST_MULT_CODE_X2 = 3'h0;
  localparam logic [2:0] CST_MULT_CODE_X3 = 3'h1;
  localparam logic [2:0] CST_MULT_CODE_X4 = 3'h2;
  localparam logic [2:0] CST_MULT_RATIO_X2 = 3'h2;
  localparam logic [2:0] CST_MULT_RATIO_X3 = 3'h3;
  localparam logic [2:0] CST_MULT_RATIO_X4 = 3'h4;
  localparam logic [2:0] CST_MULT_RATIO_NONE = 3'h0;

  // Boot memory port width codes.
  localparam logic [1:0] CST_WIDTH_8 = 2'h0;
  localparam logic [1:0] CST_WIDTH_16 = 2'h1;
  localparam logic [1:0] CST_WIDTH_32 = 2'h2;
  localparam logic [1:0] CST_WIDTH_RSV = 2'h3;

  // Boot source codes.
  localparam logic [1:0] CST_BOOT_STANDARD = 2'h0;
  localparam logic [1:0] CST_BOOT_PCI = 2'h1;
  localparam logic [1:0] CST_BOOT_RSV = 2'h2;
  localparam logic [1:0] CST_BOOT_TRISTATE = 2'h3;

  // PCI role strap levels.
  localparam logic CST_PCI_SATELLITE = 1'h1;
  localparam logic CST_PCI_HOST = 1'h0;

  // Internal register block base addresses.
  localparam logic [31:0] CST_REG_BASE_DEFAULT = 32'h1800_0000;
  localparam logic [31:0] CST_REG_BASE_RELOC = 32'h1900_0000;

  // Trace status codes.
  localparam logic [2:0] CST_TRACE_STALL_CODE = 3'h7;
  localparam logic [2:0] CST_TRACE_BRANCH_PC_CODE = 3'h6;
  localparam logic [2:0] CST_TRACE_BRANCH_NOPC_CODE = 3'h5;
  localparam logic [2:0] CST_TRACE_EXCEPTION_CODE = 3'h4;
  localparam logic [2:0] CST_TRACE_SEQUENTIAL_CODE = 3'h3;
  localparam logic [2:0] CST_TRACE_AT_STALL_CODE = 3'h2;
  localparam logic [2:0] CST_TRACE_TRIGGER_CODE = 3'h1;
  localparam logic [2:0] CST_TRACE_DEBUG_MODE_CODE = 3'h0;

  // Values after the block reset.
  localparam logic [2:0] CST_TRACE_RESET = 3'h3;
  localparam logic [27:0] CST_BLK_ADDR_RESET = 28'h000_0000;

  // Pin phase sequencer, Gray coded along cold -> latch -> run.
  typedef enum logic [1:0]
  {
    CST_ST_COLD = 2'h0,
    CST_ST_LATCH = 2'h1,
    CST_ST_RUN = 2'h3
  } cst_state_e;

endpackage : cst_pkg

// File: rtl/cst_sync2.sv
// Two-stage level synchroniser for pins entering the clk domain.
// Assumes each bit is an independent level; multi-bit groups are quasi-static.
`timescale 1ns/1ps
`default_nettype none
module cst_sync2
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    meta_reg <= async_in;
    sync_reg <= meta_reg;
  end

  assign sync_out = sync_reg;

endmodule : cst_sync2
`default_nettype wire

// File: rtl/cst_strap_trace.sv
// Cold-reset strap capture and debug trace outputs sharing the same pins.
// Assumes core and bus event inputs are on clk; pins and JTAG arrive async.
//
// What this block does
// - Trace status pins encode pipeline state with the eight documented codes.
// - Test mode select is sampled at each rising edge of the test clock.
// - Source pin reads low for DMA, high for CPU, during strobes.
// - Acknowledge debug pin pulses low on every CPU or DMA data acknowledge.
// - Start strobe pulses low at transaction start with block address shown.
// - Instruction pin reads low for data, high for instruction fetch.
// - Byte order bit 3 is latched from instruction pin during cold reset.
// - Mode bits 2:0 pick core clock ratio 2, 3 or 4; others reserved.
// - Mode bit 6 low enables the timer interrupt, high disables it.
// - Mode bits 9:8 pick boot port width 8, 16 or 32 bits.
// - Boot code 11 tri-states memory and EEPROM buses during cold reset.
// - Boot code 01 with satellite role resets on PCI reset, boots over PCI.
// - Boot code 00 boots from the local memory controller.
// - Non-boot mode allows moving register base from 1800_0000 to 1900_0000.
// - Address line 20 strap picks PCI satellite when high, host when low.
// - Satellite PCI boot loads read-only PCI configuration from EEPROM.
// - Straps are captured only by cold reset, never by other resets.
`timescale 1ns/1ps
`default_nettype none
module cst_strap_trace
  import cst_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cold_reset_n,
  input wire logic pci_reset_n,
  input wire logic jtag_tck,
  input wire logic jtag_tms,
  input wire logic [2:0] pcst_in,
  output logic [2:0] pcst_out,
  output logic [2:0] pcst_oe,
  input wire logic dma_n_in,
  output logic dma_n_out,
  output logic dma_n_oe,
  input wire logic ack_n_in,
  output logic ack_n_out,
  output logic ack_n_oe,
  input wire logic ads_n_in,
  output logic ads_n_out,
  output logic ads_n_oe,
  input wire logic i_d_n_in,
  output logic i_d_n_out,
  output logic i_d_n_oe,
  input wire logic [CST_ADDR_MSB:CST_ADDR_LSB] mem_addr_strap,
  output logic [31:4] blk_addr_out,
  input wire logic core_stall,
  input wire logic core_branch_pc,
  input wire logic core_branch_nopc,
  input wire logic core_exception,
  input wire logic core_trace_at_stall,
  input wire logic core_trace_trigger,
  input wire logic core_debug_mode,
  input wire logic txn_start,
  input wire logic txn_is_dma,
  input wire logic txn_is_ifetch,
  input wire logic [31:4] txn_block_addr,
  input wire logic data_ack,
  input wire logic ack_is_dma,
  input wire logic ack_is_ifetch,
  input wire logic base_relocate,
  output logic tms_sample,
  output logic tms_sample_valid,
  output logic strap_valid,
  output logic [2:0] core_clk_mult,
  output logic clk_mult_reserved,
  output logic byte_order_select,
  output logic timer_irq_disable,
  output logic timer_irq_enable,
  output logic [1:0] boot_port_width,
  output logic boot_width_reserved,
  output logic strap_reserved_error,
  output logic [1:0] boot_source,
  output logic boot_local,
  output logic boot_pci,
  output logic boot_source_reserved,
  output logic pci_satellite,
  output logic pci_cfg_sw_write,
  output logic pci_cfg_from_eeprom,
  output logic mem_bus_tristate,
  output logic eeprom_bus_tristate,
  output logic core_reset,
  output logic [31:0] reg_base_addr
);

  // Pin synchronisers.
  logic cold_n_sync;
  logic pci_reset_n_sync;
  logic [1:0] jtag_sync;
  logic [6:0] dbg_pin_sync;
  logic [CST_ADDR_MSB:CST_ADDR_LSB] addr_sync;

  cst_sync2 #(.WIDTH(2)) u_sync_rst
  (
    .clk(clk),
    .async_in({cold_reset_n, pci_reset_n}),
    .sync_out({cold_n_sync, pci_reset_n_sync})
  );

  cst_sync2 #(.WIDTH(2)) u_sync_jtag
  (
    .clk(clk),
    .async_in({jtag_tck, jtag_tms}),
    .sync_out(jtag_sync)
  );

  cst_sync2 #(.WIDTH(7)) u_sync_dbg
  (
    .clk(clk),
    .async_in({pcst_in, dma_n_in, ack_n_in, ads_n_in, i_d_n_in}),
    .sync_out(dbg_pin_sync)
  );

  cst_sync2 #(.WIDTH(CST_ADDR_MSB - CST_ADDR_LSB + 1)) u_sync_addr
  (
    .clk(clk),
    .async_in(mem_addr_strap),
    .sync_out(addr_sync)
  );

  logic cold_active;
  assign cold_active = ~cold_n_sync;

  // Mode word as currently presented on the shared pins.
  logic [CST_MODE_W-1:0] mode_live;
  // Pin order is dma, ack, ads, i_d, but the mode word puts ads above ack.
  assign mode_live = {addr_sync[CST_ADDR_WIDTH_MSB:CST_ADDR_WIDTH_LSB], addr_sync[CST_ADDR_RSV7],
                      dbg_pin_sync[3], dbg_pin_sync[1], dbg_pin_sync[2], dbg_pin_sync[0],
                      dbg_pin_sync[6:4]};

  // Strap registers. Only cold reset loads them, so a PCI or block reset
  // leaves the boot configuration intact.
  logic [CST_MODE_W-1:0] mode_reg;
  logic [1:0] boot_reg;
  logic pci_role_reg;
  logic strap_valid_reg;

  always_ff @(posedge clk)
  begin
    if (cold_active)
    begin
      mode_reg <= mode_live;
      boot_reg <= addr_sync[CST_ADDR_BOOT_MSB:CST_ADDR_BOOT_LSB];
      pci_role_reg <= addr_sync[CST_ADDR_PCI_ROLE];
    end
  end

  always_ff @(posedge clk)
  begin
    strap_valid_reg <= ~cold_active;
  end

  // Pin phase sequencer; one latch cycle separates capture from driving.
  cst_state_e state_reg;
  cst_state_e state_next;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CST_ST_COLD: state_next = cold_active ? CST_ST_COLD : CST_ST_LATCH;
      CST_ST_LATCH: state_next = cold_active ? CST_ST_COLD : CST_ST_RUN;
      CST_ST_RUN: state_next = cold_active ? CST_ST_COLD : CST_ST_RUN;
      default: state_next = CST_ST_COLD;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset || cold_active)
      state_reg <= CST_ST_COLD;
    else
      state_reg <= state_next;
  end

  logic drive_en;
  // The sequencer leaves RUN one cycle after cold reset is seen, so the
  // pins are also released directly to avoid fighting the strap resistors.
  assign drive_en = (state_reg == CST_ST_RUN) && !cold_active;

  // Priority order favours the states a probe can least afford to miss.
  function automatic logic [2:0] trace_encode(input logic dbg, input logic exc,
                                              input logic trig, input logic tstall,
                                              input logic stall, input logic bpc,
                                              input logic bnopc);
    logic [2:0] code;
    code = CST_TRACE_SEQUENTIAL_CODE;
    if (dbg)
      code = CST_TRACE_DEBUG_MODE_CODE;
    else if (exc)
      code = CST_TRACE_EXCEPTION_CODE;
    else if (trig)
      code = CST_TRACE_TRIGGER_CODE;
    else if (tstall)
      code = CST_TRACE_AT_STALL_CODE;
    else if (stall)
      code = CST_TRACE_STALL_CODE;
    else if (bpc)
      code = CST_TRACE_BRANCH_PC_CODE;
    else if (bnopc)
      code = CST_TRACE_BRANCH_NOPC_CODE;
    return code;
  endfunction : trace_encode

  logic [2:0] pcst_reg;

  always_ff @(posedge clk)
  begin
    if (reset || !drive_en)
      pcst_reg <= CST_TRACE_RESET;
    else
      pcst_reg <= trace_encode(core_debug_mode, core_exception, core_trace_trigger,
                               core_trace_at_stall, core_stall, core_branch_pc,
                               core_branch_nopc);
  end

  // Transaction attribute strobes. A start in the same cycle as an ack
  // supplies the attributes, since the start carries the new block.
  logic ads_n_reg;
  logic ack_n_reg;
  logic dma_n_reg;
  logic i_d_n_reg;
  logic [27:0] blk_addr_reg;

  always_ff @(posedge clk)
  begin
    if (reset || !drive_en)
    begin
      ads_n_reg <= 1'h1;
      ack_n_reg <= 1'h1;
    end
    else
    begin
      ads_n_reg <= ~txn_start;
      ack_n_reg <= ~data_ack;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || !drive_en)
    begin
      dma_n_reg <= 1'h1;
      i_d_n_reg <= 1'h1;
    end
    else if (txn_start)
    begin
      dma_n_reg <= ~txn_is_dma;
      i_d_n_reg <= txn_is_ifetch;
    end
    else if (data_ack)
    begin
      dma_n_reg <= ~ack_is_dma;
      i_d_n_reg <= ack_is_ifetch;
    end
    else
    begin
      dma_n_reg <= 1'h1;
      i_d_n_reg <= 1'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      blk_addr_reg <= CST_BLK_ADDR_RESET;
    else if (txn_start)
      blk_addr_reg <= txn_block_addr;
  end

  // Test mode select capture. The test clock is oversampled, so its period
  // must exceed two clk periods for no edge to be lost.
  logic tck_prev_reg;
  logic tms_sample_reg;
  logic tms_valid_reg;
  logic tck_rise;
  assign tck_rise = jtag_sync[1] & ~tck_prev_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tck_prev_reg <= 1'h0;
      tms_sample_reg <= 1'h1;
      tms_valid_reg <= 1'h0;
    end
    else
    begin
      tck_prev_reg <= jtag_sync[1];
      tms_valid_reg <= tck_rise;
      if (tck_rise)
        tms_sample_reg <= jtag_sync[0];
    end
  end

  // Register base relocation, permitted only in the non-boot mode.
  logic reloc_reg;

  always_ff @(posedge clk)
  begin
    if (cold_active)
      reloc_reg <= 1'h0;
    else if (base_relocate && boot_reg == CST_BOOT_TRISTATE)
      reloc_reg <= 1'h1;
  end

  // Pin drive.
  assign pcst_out = pcst_reg;
  assign pcst_oe = {3{drive_en}};
  assign dma_n_out = dma_n_reg;
  assign dma_n_oe = drive_en;
  assign ack_n_out = ack_n_reg;
  assign ack_n_oe = drive_en;
  assign ads_n_out = ads_n_reg;
  assign ads_n_oe = drive_en;
  assign i_d_n_out = i_d_n_reg;
  assign i_d_n_oe = drive_en;
  assign blk_addr_out = blk_addr_reg;
  assign tms_sample = tms_sample_reg;
  assign tms_sample_valid = tms_valid_reg;

  // Configuration decode.
  logic [2:0] mult_code;
  assign mult_code = mode_reg[CST_MB_MULT_MSB:CST_MB_MULT_LSB];
  assign strap_valid = strap_valid_reg;
  assign core_clk_mult = (mult_code == CST_MULT_CODE_X2) ? CST_MULT_RATIO_X2 :
                         (mult_code == CST_MULT_CODE_X3) ? CST_MULT_RATIO_X3 :
                         (mult_code == CST_MULT_CODE_X4) ? CST_MULT_RATIO_X4 :
                         CST_MULT_RATIO_NONE;
  assign clk_mult_reserved = (core_clk_mult == CST_MULT_RATIO_NONE);
  assign byte_order_select = mode_reg[CST_MB_BYTE_ORDER];
  assign timer_irq_disable = mode_reg[CST_MB_TIMER_DIS];
  assign timer_irq_enable = ~mode_reg[CST_MB_TIMER_DIS];
  assign boot_port_width = mode_reg[CST_MB_WIDTH_MSB:CST_MB_WIDTH_LSB];
  assign boot_width_reserved = (boot_port_width == CST_WIDTH_RSV);
  assign strap_reserved_error = (mode_reg[CST_MB_RSV4] != CST_RSV4_LEVEL) ||
                                (mode_reg[CST_MB_RSV5] != CST_RSV5_LEVEL) ||
                                (mode_reg[CST_MB_RSV7] != CST_RSV7_LEVEL);
  assign boot_source = boot_reg;
  assign boot_local = (boot_reg == CST_BOOT_STANDARD);
  assign pci_satellite = (pci_role_reg == CST_PCI_SATELLITE);
  assign boot_pci = (boot_reg == CST_BOOT_PCI) && pci_satellite;
  assign boot_source_reserved = (boot_reg == CST_BOOT_RSV);
  assign pci_cfg_sw_write = ~pci_satellite;
  assign pci_cfg_from_eeprom = boot_pci;
  // The live strap is used because the bus must float before capture ends.
  assign mem_bus_tristate = cold_active &&
    (addr_sync[CST_ADDR_BOOT_MSB:CST_ADDR_BOOT_LSB] == CST_BOOT_TRISTATE);
  assign eeprom_bus_tristate = mem_bus_tristate;
  assign core_reset = cold_active || (boot_pci && !pci_reset_n_sync);
  assign reg_base_addr = reloc_reg ? CST_REG_BASE_RELOC : CST_REG_BASE_DEFAULT;

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_TRACE_STALL: assert property (drive_en && core_stall && !core_debug_mode && !core_exception
    && !core_trace_trigger && !core_trace_at_stall |=> pcst_out == CST_TRACE_STALL_CODE)
    else $error("Stall not shown as trace code 111.");
  AST_TMS_SAMPLE: assert property (tck_rise |=> tms_sample_valid
    && tms_sample == $past(jtag_sync[0]))
    else $error("Test mode select not taken at test clock rise.");
  AST_DMA_SOURCE: assert property (drive_en && txn_start && txn_is_dma
    |=> !dma_n_out && !ads_n_out)
    else $error("DMA start not marked low on source pin.");
  AST_ACK_STROBE: assert property (drive_en ##0 data_ack |=> !ack_n_out ##1
    (ack_n_out || $past(data_ack)))
    else $error("Acknowledge strobe does not follow data acknowledge.");
  AST_START_ADDR: assert property (drive_en && txn_start |=> !ads_n_out
    && blk_addr_out == $past(txn_block_addr))
    else $error("Start strobe without its block address.");
  AST_IFETCH: assert property (drive_en && txn_start && txn_is_ifetch |=> i_d_n_out)
    else $error("Instruction fetch not marked high.");
  AST_BYTE_ORDER: assert property ($fell(cold_active) |->
    byte_order_select == $past(dbg_pin_sync[0]))
    else $error("Byte order not latched from the instruction pin.");
  AST_CLK_MULT: assert property (strap_valid && mult_code == CST_MULT_CODE_X4
    |-> core_clk_mult == CST_MULT_RATIO_X4 && !clk_mult_reserved)
    else $error("Clock ratio decode wrong.");
  AST_TRISTATE: assert property (mem_bus_tristate |-> cold_active && !drive_en)
    else $error("Bus tri-state outside cold reset.");
  AST_PCI_RESET: assert property (strap_valid && boot_pci && !pci_reset_n_sync
    |-> core_reset)
    else $error("PCI reset ignored in PCI boot mode.");
  AST_STRAP_HOLD: assert property (!cold_active && $past(!cold_active)
    |-> $stable(mode_reg) && $stable(boot_reg))
    else $error("Straps changed outside cold reset.");
  AST_NO_DRIVE_COLD: assert property (cold_active |=> !pcst_oe[0] && !ads_n_oe ##1
    (!cold_active || !dma_n_oe))
    else $error("Shared pins driven during cold reset.");

  COV_PCI_BOOT: cover property (strap_valid && boot_pci ##1 core_reset);
  COV_TRISTATE: cover property (mem_bus_tristate ##1 !cold_active);
  COV_RUN_START: cover property (drive_en && txn_start ##1 data_ack);
  COV_RELOCATE: cover property ($rose(reg_base_addr[24]));

endmodule : cst_strap_trace
`default_nettype wire

// File: bench/cst_board_model.sv
// Board model: strap resistors behind the shared debug pins and the address straps.
// Assumes the device releases a pin by lowering its enable; the resistor then sets the level.
`timescale 1ns/1ps
`default_nettype none
module cst_board_model
(
  input wire logic [2:0] pcst_out,
  input wire logic [2:0] pcst_oe,
  input wire logic [3:0] dbg_out,
  input wire logic [3:0] dbg_oe,
  input wire logic [9:0] mode_strap,
  input wire logic [1:0] boot_strap,
  input wire logic role_strap,
  output logic [2:0] pcst_in,
  output logic [3:0] dbg_in,
  output logic [22:17] addr_pins
);
  // A released pin never keeps the last driven level; the resistor wins at once.
  always_comb
  begin
    for (int b = 0; b < 3; b++)
      pcst_in[b] = pcst_oe[b] ? pcst_out[b] : mode_strap[b];
    for (int b = 0; b < 4; b++)
      dbg_in[b] = dbg_oe[b] ? dbg_out[b] : mode_strap[b + 3];
  end

  // Address straps are resistors only, so they hold their level all the time.
  assign addr_pins = {boot_strap, role_strap, mode_strap[9:7]};
endmodule : cst_board_model
`default_nettype wire

// File: bench/cst_strap_trace_test.sv
// Self-checking bench for the strap capture and debug trace block.
// Assumes the board model in cst_board_model.sv and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module cst_strap_trace_test
  import cst_pkg::*;
;
  logic clk = 1'h0, reset = 1'h1, cold_reset_n = 1'h0, pci_reset_n = 1'h1;
  logic jtag_tck = 1'h0, jtag_tms = 1'h1, base_relocate = 1'h0;
  logic [6:0] core_ev = 7'h00;
  logic txn_start = 1'h0, txn_is_dma = 1'h0, txn_is_ifetch = 1'h0;
  logic data_ack = 1'h0, ack_is_dma = 1'h0, ack_is_ifetch = 1'h0;
  logic [31:4] txn_block_addr = 28'h000_0000;
  logic [9:0] mode_strap = 10'h080;
  logic [1:0] boot_strap = 2'h0;
  logic role_strap = 1'h0;
  logic [2:0] pcst_in, pcst_out, pcst_oe, core_clk_mult;
  logic [3:0] dbg_in;
  wire [3:0] dbg_out, dbg_oe;
  logic [22:17] addr_pins;
  logic [31:4] blk_addr_out;
  logic tms_sample, tms_sample_valid, strap_valid, clk_mult_reserved, byte_order_select;
  logic timer_irq_disable, timer_irq_enable, boot_width_reserved, strap_reserved_error;
  logic boot_local, boot_pci, boot_source_reserved, pci_satellite, pci_cfg_sw_write;
  logic pci_cfg_from_eeprom, mem_bus_tristate, eeprom_bus_tristate, core_reset;
  logic [1:0] boot_port_width, boot_source;
  logic [31:0] reg_base_addr;
  // Trace code expected when the given core state bit is the highest one set.
  logic [2:0] exp_code [7] = '{3'h5, 3'h6, 3'h7, 3'h2, 3'h1, 3'h4, 3'h0};
  int n_errors = 0, n_checks = 0, cycles = 0;

  always #20 clk = ~clk;

  cst_board_model u_board (.pcst_out, .pcst_oe, .dbg_out, .dbg_oe, .mode_strap, .boot_strap,
    .role_strap, .pcst_in, .dbg_in, .addr_pins);

  cst_strap_trace u_dut (.clk, .reset, .cold_reset_n, .pci_reset_n, .jtag_tck, .jtag_tms,
    .pcst_in, .pcst_out, .pcst_oe, .dma_n_in(dbg_in[3]), .dma_n_out(dbg_out[3]),
    .dma_n_oe(dbg_oe[3]), .ads_n_in(dbg_in[2]), .ads_n_out(dbg_out[2]), .ads_n_oe(dbg_oe[2]),
    .ack_n_in(dbg_in[1]), .ack_n_out(dbg_out[1]), .ack_n_oe(dbg_oe[1]),
    .i_d_n_in(dbg_in[0]), .i_d_n_out(dbg_out[0]), .i_d_n_oe(dbg_oe[0]),
    .mem_addr_strap(addr_pins), .blk_addr_out, .core_branch_nopc(core_ev[0]),
    .core_branch_pc(core_ev[1]), .core_stall(core_ev[2]), .core_trace_at_stall(core_ev[3]),
    .core_trace_trigger(core_ev[4]), .core_exception(core_ev[5]),
    .core_debug_mode(core_ev[6]), .txn_start, .txn_is_dma, .txn_is_ifetch, .txn_block_addr,
    .data_ack, .ack_is_dma, .ack_is_ifetch, .base_relocate, .tms_sample, .tms_sample_valid,
    .strap_valid, .core_clk_mult, .clk_mult_reserved, .byte_order_select, .timer_irq_disable,
    .timer_irq_enable, .boot_port_width, .boot_width_reserved, .strap_reserved_error,
    .boot_source, .boot_local, .boot_pci, .boot_source_reserved, .pci_satellite,
    .pci_cfg_sw_write, .pci_cfg_from_eeprom, .mem_bus_tristate, .eeprom_bus_tristate,
    .core_reset, .reg_base_addr);

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  // Inputs always move one nanosecond after the rising edge, well clear of sampling.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic cold_boot(input logic [2:0] i);
    logic pci;
    // Two runs break the reserved levels on purpose to provoke the error flag.
    mode_strap = {i[1:0], i != 3'h6, i[1], 1'h0, i == 3'h5, i[0], i};
    boot_strap = i[1:0];
    role_strap = i[2];
    pci = (i[1:0] == 2'h1) && i[2];
    cold_reset_n = 1'h0;
    tick(4);
    check(pcst_oe, 3'h0);
    check(dbg_oe, 4'h0);
    check(mem_bus_tristate, i[1:0] == 2'h3);
    check(eeprom_bus_tristate, i[1:0] == 2'h3);
    tick(2);
    cold_reset_n = 1'h1;
    for (int k = 0; k < 8 && strap_valid !== 1'h1; k++)
      tick(1);
    check(pcst_oe, 3'h0);
    tick(1);
    check({pcst_oe, dbg_oe}, 7'h7F);
    check(core_clk_mult, i == 3'h0 ? 3'h2 : i == 3'h1 ? 3'h3 : i == 3'h2 ? 3'h4 : 3'h0);
    check(clk_mult_reserved, i > 3'h2);
    check(byte_order_select, i[0]);
    check({timer_irq_disable, timer_irq_enable}, {i[1], !i[1]});
    check(boot_port_width, i[1:0]);
    check(boot_width_reserved, i[1:0] == 2'h3);
    check(strap_reserved_error, i == 3'h5 || i == 3'h6);
    check(boot_source, i[1:0]);
    check(boot_local, i[1:0] == 2'h0);
    check(boot_pci, pci);
    check(boot_source_reserved, i[1:0] == 2'h2);
    check(pci_satellite, i[2]);
    check(pci_cfg_sw_write, !i[2]);
    check(pci_cfg_from_eeprom, pci);
    check(mem_bus_tristate, 1'h0);
    check(reg_base_addr, 32'h1800_0000);
    base_relocate = 1'h1;
    tick(1);
    base_relocate = 1'h0;
    tick(3);
    check(reg_base_addr, i[1:0] == 2'h3 ? 32'h1900_0000 : 32'h1800_0000);
    pci_reset_n = 1'h0;
    tick(4);
    check(core_reset, pci);
    pci_reset_n = 1'h1;
    tick(4);
    check(core_reset, 1'h0);
  endtask : cold_boot

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1500)
    begin
      n_errors++;
      stop_test();
    end
  end

  initial
  begin
    tick(16);
    reset = 1'h0;
    for (int i = 0; i < 8; i++)
      cold_boot(3'(i));
    // Pins show inverted straps while released after a block reset; nothing may be retaken.
    mode_strap = ~mode_strap;
    role_strap = 1'h0;
    reset = 1'h1;
    tick(1);
    reset = 1'h0;
    check(pcst_oe, 3'h0);
    tick(3);
    check({core_clk_mult, pci_satellite, boot_port_width}, 6'h07);
    for (int k = 0; k < 8; k++)
    begin
      core_ev = 7'((8'h01 << k) - 8'h01);
      tick(1);
      check(pcst_out, k == 0 ? 3'h3 : exp_code[k - 1]);
    end
    core_ev = 7'h00;
    for (int k = 0; k < 4; k++)
    begin
      txn_start = 1'h1;
      txn_is_dma = k[0];
      txn_is_ifetch = k[1];
      txn_block_addr = 28'hABC_DEF0 + 28'(k);
      tick(1);
      txn_start = 1'h0;
      data_ack = 1'h1;
      ack_is_dma = !k[0];
      ack_is_ifetch = !k[1];
      check(blk_addr_out, 28'hABC_DEF0 + 28'(k));
      check(dbg_out, {!k[0], 1'h0, 1'h1, k[1]});
      tick(1);
      data_ack = 1'h0;
      check(dbg_out, {k[0], 1'h1, 1'h0, !k[1]});
      tick(1);
      check(dbg_out, 4'hF);
    end
    for (int k = 0; k < 2; k++)
    begin
      jtag_tms = k[0];
      tick(3);
      jtag_tck = 1'h1;
      for (int w = 0; w < 8 && tms_sample_valid !== 1'h1; w++)
        tick(1);
      check(tms_sample, k[0]);
      tick(1);
      check(tms_sample_valid, 1'h0);
      jtag_tck = 1'h0;
      tick(4);
    end
    stop_test();
  end
endmodule : cst_strap_trace_test
`default_nettype wire
